// *** pkg/fep_defines.svh ***
// Offsets, field positions, reset values and timing counts of the flash erase/protect controller.
`ifndef FEP_DEFINES_SVH
`define FEP_DEFINES_SVH

// Register byte offsets on the APB side.
`define FEP_OFF_CTRL      8'h00
`define FEP_OFF_STATUS    8'h04
`define FEP_OFF_PINS      8'h08
`define FEP_OFF_RDATA     8'h0C
`define FEP_OFF_TBL_BASE  8'h20
`define FEP_OFF_TBL_END   8'h60

// Control register fields.
`define FEP_CTRL_START    0
`define FEP_CTRL_OP_LO    1
`define FEP_CTRL_CNT_LO   4

// Status register fields.
`define FEP_ST_BUSY       0
`define FEP_ST_DONE       1
`define FEP_ST_REFUSED    2
`define FEP_ST_RDY        3
`define FEP_ST_TGL_MAIN   4
`define FEP_ST_TGL_TWO    5

// Pin control register fields and reset value.
`define FEP_PIN_HWRST     0
`define FEP_PIN_RST_HV    1
`define FEP_PIN_A9_HV     2
`define FEP_PIN_OE_HV     3
`define FEP_PINS_RESET    4'h0

// Status flag positions in a read-back word.
`define FEP_DQ_TGL_TWO    2
`define FEP_DQ_TGL_MAIN   6

// Clock and timing figures, each with its cycle count.
`define FEP_CLK_NS        50
`define FEP_SETUP_CYC     1
`define FEP_WE_PULSE_NS   50
`define FEP_WE_CYC        ((`FEP_WE_PULSE_NS + `FEP_CLK_NS - 1) / `FEP_CLK_NS)
`define FEP_READ_NS       100
`define FEP_SYNC_CYC      3
`define FEP_READ_CYC      (((`FEP_READ_NS + `FEP_CLK_NS - 1) / `FEP_CLK_NS) + `FEP_SYNC_CYC)
`define FEP_PPLH_US       100
`define FEP_PPLH_CYC      ((`FEP_PPLH_US * 1000 + `FEP_CLK_NS - 1) / `FEP_CLK_NS)
`define FEP_BEH_US        50
`define FEP_BEH_CYC       ((`FEP_BEH_US * 1000) / `FEP_CLK_NS)

`endif

// *** pkg/fep_pkg.sv ***
// Types shared by the flash erase/protect controller modules.
package fep_pkg;

	// Operations that software can start through the control register.
	typedef enum logic [2:0] {
		OP_SEQ    = 3'b000,
		OP_READ   = 3'b001,
		OP_TOGGLE = 3'b010,
		OP_PROT1  = 3'b011,
		OP_PROT2  = 3'b100
	} fep_op_t;

	// Sequencer states of the top module.
	typedef enum logic [1:0] {
		SQ_IDLE  = 2'b00,
		SQ_ISSUE = 2'b01,
		SQ_WAIT  = 2'b10,
		SQ_PAUSE = 2'b11
	} fep_sq_t;

	// States of one flash bus cycle.
	typedef enum logic [1:0] {
		BC_IDLE   = 2'b00,
		BC_SETUP  = 2'b01,
		BC_STROBE = 2'b10,
		BC_HOLD   = 2'b11
	} fep_bc_t;

endpackage : fep_pkg

// *** design/fep_bus_cycle.sv ***
// One asynchronous flash bus cycle, write or read, driven from the system clock.
`timescale 1ns/1ns
`include "fep_defines.svh"
module fep_bus_cycle #(
	parameter int ADDR_W = 21,
	parameter int DATA_W = 16,
	parameter int CNT_W  = 16
) (
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	input  wire logic              start,
	input  wire logic              rd,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [CNT_W-1:0]  strobe_cycles,
	input  wire logic [DATA_W-1:0] dq_in,
	output logic                   done,
	output logic [DATA_W-1:0]      rd_data,
	output logic [ADDR_W-1:0]      addr_pin,
	output logic [DATA_W-1:0]      dq_out,
	output logic                   dq_oe,
	output logic                   ce_n,
	output logic                   we_n,
	output logic                   oe_n
);
	import fep_pkg::*;

	initial
	begin
		if (CNT_W < 12 || DATA_W < 8)
			$error("fep_bus_cycle: counter or data width too small");
	end

	fep_bc_t             state_ff;      // Phase of the current cycle.
	logic [CNT_W-1:0]    cnt_ff;        // Cycles left in the current phase.
	logic                rd_ff;         // The cycle in flight is a read.
	logic [DATA_W-1:0]   dq_s1_ff;      // Data pin synchroniser, first stage.
	logic [DATA_W-1:0]   dq_s2_ff;      // Second stage.
	logic [DATA_W-1:0]   dq_s3_ff;      // Third stage.
	logic                last_w;        // The strobe count has run out; a read also waits for a stable word.
	logic                dq_stable_w;   // Second and third stage agree.

	assign last_w      = (cnt_ff <= CNT_W'(1));
	assign dq_stable_w = (dq_s2_ff == dq_s3_ff);

	// The read data passes three flops; only stages two and three are compared.
	always_ff @(posedge ref_clk)
	begin
		dq_s1_ff <= dq_in;
		dq_s2_ff <= dq_s1_ff;
		dq_s3_ff <= dq_s2_ff;
	end

	// Address is set up before the strobe falls, so the device latches it on
	// the falling edge; write data is held past the rising edge for its latch.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			state_ff <= BC_IDLE;
			cnt_ff   <= '0;
			rd_ff    <= 1'b0;
			done     <= 1'b0;
			rd_data  <= '0;
			addr_pin <= '0;
			dq_out   <= '0;
			dq_oe    <= 1'b0;
			ce_n     <= 1'b1;
			we_n     <= 1'b1;
			oe_n     <= 1'b1;
		end
		else
		begin
			done <= 1'b0;
			case (state_ff)
				BC_IDLE:
				begin
					if (start)
					begin
						// Chip select and address go first; strobes stay high.
						state_ff <= BC_SETUP;
						rd_ff    <= rd;
						addr_pin <= addr;
						dq_out   <= wdata;
						dq_oe    <= ~rd;
						ce_n     <= 1'b0;
						cnt_ff   <= strobe_cycles;
					end
				end
				BC_SETUP:
				begin
					// Open the strobe that this cycle uses.
					state_ff <= BC_STROBE;
					we_n     <= rd_ff;
					oe_n     <= ~rd_ff;
				end
				BC_STROBE:
				begin
					if (!last_w)
						cnt_ff <= cnt_ff - CNT_W'(1);
					else if (!rd_ff || dq_stable_w)
					begin
						// A read waits here until the synchronised word settles.
						state_ff <= BC_HOLD;
						we_n     <= 1'b1;
						oe_n     <= 1'b1;
						if (rd_ff)
							rd_data <= dq_s3_ff;
					end
				end
				BC_HOLD:
				begin
					// Write data and chip select held one cycle past the rising edge.
					state_ff <= BC_IDLE;
					ce_n     <= 1'b1;
					dq_oe    <= 1'b0;
					done     <= 1'b1;
				end
				default:
				begin
					state_ff <= BC_IDLE;
				end
			endcase
		end
	end

endmodule : fep_bus_cycle

// *** design/fep_host.sv ***
// APB-controlled host that drives a parallel NOR flash through erase, suspend and protection.
//
// Overview of operation
// - After erase failure host issues reset command. The host detects no failure; software loads the reset command as a sequence.
// - Extra block cycles follow within erase hold time.
// - Protect one: high voltage, fixed bits, pulse.
// - Protect two: four cycles under high voltage reset.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ns
`include "fep_defines.svh"
module fep_host #(
	parameter int ADDR_W   = 21,
	parameter int DATA_W   = 16,
	parameter int TBL_N    = 8,
	parameter int PPLH_CYC = `FEP_PPLH_CYC,
	parameter int BEH_CYC  = `FEP_BEH_CYC
) (
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic [ADDR_W-1:0]      flash_addr,
	input  wire logic [DATA_W-1:0] flash_dq_in,
	output logic [DATA_W-1:0]      flash_dq_out,
	output logic                   flash_dq_oe,
	output logic                   flash_ce_n,
	output logic                   flash_we_n,
	output logic                   flash_oe_n,
	output logic                   flash_reset_n,
	output logic                   reset_hv_en,
	output logic                   a9_hv_en,
	output logic                   oe_hv_en,
	input  wire logic              ready_busy_in
);
	import fep_pkg::*;

	localparam int CNT_W = 16;

	initial
	begin
		if (TBL_N != 8 || ADDR_W < 7 || PPLH_CYC >= 65536 || BEH_CYC < 16)
			$error("fep_host: parameter outside what the sequencer serves");
	end

	// Forces the protect address pattern: bit 1 high, bits 0 and 6 low.
	function automatic logic [ADDR_W-1:0] fep_prot_addr(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] r;
		r    = a;
		r[0] = 1'b0;
		r[1] = 1'b1;
		r[6] = 1'b0;
		return r;
	endfunction : fep_prot_addr

	// Command table that software loads; each entry is one flash bus cycle.
	logic [ADDR_W-1:0]  tbl_addr_ff [TBL_N];
	logic [7:0]         tbl_data_ff [TBL_N];

	fep_sq_t            sq_ff;          // Sequencer state.
	fep_op_t            op_ff;          // Operation in flight.
	logic [3:0]         n_ff;           // Bus cycles in this operation.
	logic [2:0]         idx_ff;         // Current bus cycle number.
	logic [CNT_W-1:0]   wait_ff;        // Pause counter between protect cycles.
	logic               done_ff;        // Sticky: operation finished.
	logic               refused_ff;     // Sticky: start refused.
	logic [3:0]         pins_ff;        // Pin control register.
	logic [DATA_W-1:0]  rdata_ff;       // Last word read from the flash.
	logic [DATA_W-1:0]  prev_ff;        // First word of a toggle poll.
	logic               tgl_main_ff;    // Main toggle bit changed between reads.
	logic               tgl_two_ff;     // Second toggle bit changed between reads.
	logic               rb_s1_ff;       // Ready/busy synchroniser stages.
	logic               rb_s2_ff;
	logic               rb_s3_ff;
	logic               rb_lvl_ff;      // Accepted ready/busy level.
	logic               bc_start_ff;    // Pulse that launches one bus cycle.

	// APB decode.
	logic               apb_acc_w;      // Access phase, answer ready this edge.
	logic               wr_w;
	logic [7:0]         tbl_off_w;
	logic               tbl_hit_w;
	logic [2:0]         tbl_idx_w;
	logic               map_hit_w;
	logic [31:0]        rd_mux_w;
	logic               start_req_w;
	fep_op_t            req_op_w;
	logic [3:0]         req_n_w;
	logic               req_ok_w;

	assign apb_acc_w = psel & penable & pready;
	assign wr_w      = apb_acc_w & pwrite;
	assign tbl_off_w = paddr - `FEP_OFF_TBL_BASE;
	assign tbl_hit_w = (paddr >= `FEP_OFF_TBL_BASE) && (paddr < `FEP_OFF_TBL_END)
		&& (paddr[1:0] == 2'h0);
	assign tbl_idx_w = tbl_off_w[5:3];
	assign map_hit_w = tbl_hit_w || paddr == `FEP_OFF_CTRL || paddr == `FEP_OFF_STATUS
		|| paddr == `FEP_OFF_PINS || paddr == `FEP_OFF_RDATA;

	// A start carries its operation and, for a plain sequence, its cycle count.
	assign start_req_w = wr_w && paddr == `FEP_OFF_CTRL && pwdata[`FEP_CTRL_START];
	assign req_op_w    = fep_op_t'(pwdata[`FEP_CTRL_OP_LO +: 3]);
	assign req_n_w     = (req_op_w == OP_SEQ)    ? pwdata[`FEP_CTRL_CNT_LO +: 4] :
	                     (req_op_w == OP_TOGGLE) ? 4'h2 :
	                     (req_op_w == OP_PROT2)  ? 4'h4 : 4'h1;
	// Protect one needs both high voltage switches; protect two the reset one.
	assign req_ok_w = (sq_ff == SQ_IDLE) && req_n_w != 4'h0 && req_n_w <= 4'h8
		&& req_op_w <= OP_PROT2
		&& (req_op_w != OP_PROT1 || (pins_ff[`FEP_PIN_A9_HV] && pins_ff[`FEP_PIN_OE_HV]))
		&& (req_op_w != OP_PROT2 || pins_ff[`FEP_PIN_RST_HV]);

	// Read multiplexer; unused bits read as zero.
	always_comb
	begin
		rd_mux_w = 32'h0000_0000;
		if (tbl_hit_w && !tbl_off_w[2])
			rd_mux_w[ADDR_W-1:0] = tbl_addr_ff[tbl_idx_w];
		else if (tbl_hit_w)
			rd_mux_w[7:0] = tbl_data_ff[tbl_idx_w];
		else if (paddr == `FEP_OFF_STATUS)
			rd_mux_w[5:0] = {tgl_two_ff, tgl_main_ff, rb_lvl_ff, refused_ff, done_ff,
				sq_ff != SQ_IDLE};
		else if (paddr == `FEP_OFF_PINS)
			rd_mux_w[3:0] = pins_ff;
		else if (paddr == `FEP_OFF_RDATA)
			rd_mux_w[DATA_W-1:0] = rdata_ff;
	end

	// One wait state: the answer is registered, then taken on the next edge.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~map_hit_w;
			prdata  <= rd_mux_w;
		end
	end

	// Table writes; unmapped writes change nothing.
	always_ff @(posedge ref_clk)
	begin
		if (wr_w && tbl_hit_w && !tbl_off_w[2])
			tbl_addr_ff[tbl_idx_w] <= pwdata[ADDR_W-1:0];
		if (wr_w && tbl_hit_w && tbl_off_w[2])
			tbl_data_ff[tbl_idx_w] <= pwdata[7:0];
	end

	// Pin control: hardware reset and the high voltage switches.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			pins_ff <= `FEP_PINS_RESET;
		else if (wr_w && paddr == `FEP_OFF_PINS)
			pins_ff <= pwdata[3:0];
	end

	// The pin outputs are registered copies of the pin control register, the hardware reset bit inverted.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			flash_reset_n <= 1'b1;
			reset_hv_en   <= 1'b0;
			a9_hv_en      <= 1'b0;
			oe_hv_en      <= 1'b0;
		end
		else
		begin
			flash_reset_n <= ~pins_ff[`FEP_PIN_HWRST];
			reset_hv_en   <= pins_ff[`FEP_PIN_RST_HV];
			a9_hv_en      <= pins_ff[`FEP_PIN_A9_HV];
			oe_hv_en      <= pins_ff[`FEP_PIN_OE_HV];
		end
	end

	// Ready/busy passes three flops; a change counts once stages two and three agree.
	always_ff @(posedge ref_clk)
	begin
		rb_s1_ff <= ready_busy_in;
		rb_s2_ff <= rb_s1_ff;
		rb_s3_ff <= rb_s2_ff;
		if (sys_rst)
			rb_lvl_ff <= 1'b1;
		else if (rb_s2_ff == rb_s3_ff)
			rb_lvl_ff <= rb_s3_ff;
	end

	// Per-cycle selection of the bus cycle to launch.
	logic              bc_done_w;
	logic [DATA_W-1:0] bc_rdata_w;
	logic [2:0]        ent_w;
	logic              cyc_rd_w;
	logic              cyc_prot_w;
	logic [ADDR_W-1:0] cyc_addr_w;
	logic [CNT_W-1:0]  cyc_len_w;
	logic              last_cyc_w;

	assign ent_w      = (op_ff == OP_TOGGLE) ? 3'h0 : idx_ff;
	assign cyc_rd_w   = op_ff == OP_READ || op_ff == OP_TOGGLE
		|| (op_ff == OP_PROT2 && idx_ff == 3'h3);
	assign cyc_prot_w = op_ff == OP_PROT1 || (op_ff == OP_PROT2 && idx_ff == 3'h1);
	assign cyc_addr_w = cyc_prot_w ? fep_prot_addr(tbl_addr_ff[ent_w])
		: tbl_addr_ff[ent_w];
	// Protect one holds the write strobe low for the whole protect pulse.
	assign cyc_len_w  = (op_ff == OP_PROT1) ? CNT_W'(PPLH_CYC) :
	                    cyc_rd_w ? CNT_W'(`FEP_READ_CYC) : CNT_W'(`FEP_WE_CYC);
	assign last_cyc_w = ({1'b0, idx_ff} + 4'h1) >= n_ff;

	// Sequencer. Cycles of one operation follow back to back, save the pause after the protect two protect write, so every extra
	// block cycle of a multi-block erase lands well inside the hold window.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sq_ff       <= SQ_IDLE;
			op_ff       <= OP_SEQ;
			n_ff        <= 4'h0;
			idx_ff      <= 3'h0;
			wait_ff     <= '0;
			bc_start_ff <= 1'b0;
			rdata_ff    <= '0;
			prev_ff     <= '0;
			tgl_main_ff <= 1'b0;
			tgl_two_ff  <= 1'b0;
		end
		else
		begin
			bc_start_ff <= 1'b0;
			case (sq_ff)
				SQ_IDLE:
				begin
					if (start_req_w && req_ok_w)
					begin
						op_ff  <= req_op_w;
						n_ff   <= req_n_w;
						idx_ff <= 3'h0;
						sq_ff  <= SQ_ISSUE;
					end
				end
				SQ_ISSUE:
				begin
					bc_start_ff <= 1'b1;
					sq_ff       <= SQ_WAIT;
				end
				SQ_WAIT:
				begin
					if (bc_done_w)
					begin
						if (cyc_rd_w)
						begin
							rdata_ff <= bc_rdata_w;
							prev_ff  <= bc_rdata_w;
						end
						// Second read of a poll: record which flags moved.
						if (op_ff == OP_TOGGLE && idx_ff == 3'h1)
						begin
							tgl_main_ff <= prev_ff[`FEP_DQ_TGL_MAIN] ^ bc_rdata_w[`FEP_DQ_TGL_MAIN];
							tgl_two_ff  <= prev_ff[`FEP_DQ_TGL_TWO] ^ bc_rdata_w[`FEP_DQ_TGL_TWO];
						end
						if (last_cyc_w)
							sq_ff <= SQ_IDLE;
						else if (op_ff == OP_PROT2 && idx_ff == 3'h1)
						begin
							// Let the protect write finish before verifying.
							wait_ff <= CNT_W'(PPLH_CYC);
							idx_ff  <= idx_ff + 3'h1;
							sq_ff   <= SQ_PAUSE;
						end
						else
						begin
							idx_ff <= idx_ff + 3'h1;
							sq_ff  <= SQ_ISSUE;
						end
					end
				end
				SQ_PAUSE:
				begin
					if (wait_ff <= CNT_W'(1))
						sq_ff <= SQ_ISSUE;
					else
						wait_ff <= wait_ff - CNT_W'(1);
				end
				default:
				begin
					sq_ff <= SQ_IDLE;
				end
			endcase
		end
	end

	// Sticky flags: a setting event wins over a write-one clear in the same cycle.
	// Recovery from a failed erase is a reset command loaded as a sequence.
	logic done_set_w;
	logic clr_w;

	assign done_set_w = sq_ff == SQ_WAIT && bc_done_w && last_cyc_w;
	assign clr_w      = wr_w && paddr == `FEP_OFF_STATUS;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			done_ff    <= 1'b0;
			refused_ff <= 1'b0;
		end
		else
		begin
			done_ff    <= done_set_w | (done_ff & ~(clr_w & pwdata[`FEP_ST_DONE]));
			refused_ff <= (start_req_w & ~req_ok_w)
				| (refused_ff & ~(clr_w & pwdata[`FEP_ST_REFUSED]));
		end
	end

	fep_bus_cycle #(
		.ADDR_W        (ADDR_W),
		.DATA_W        (DATA_W),
		.CNT_W         (CNT_W)
	) fep_bus_cycle_i (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.start         (bc_start_ff),
		.rd            (cyc_rd_w),
		.addr          (cyc_addr_w),
		.wdata         ({{(DATA_W-8){1'b0}}, tbl_data_ff[ent_w]}),
		.strobe_cycles (cyc_len_w),
		.dq_in         (flash_dq_in),
		.done          (bc_done_w),
		.rd_data       (bc_rdata_w),
		.addr_pin      (flash_addr),
		.dq_out        (flash_dq_out),
		.dq_oe         (flash_dq_oe),
		.ce_n          (flash_ce_n),
		.we_n          (flash_we_n),
		.oe_n          (flash_oe_n)
	);

	// Helper counters for the checks below.
	logic [CNT_W-1:0] we_low_cnt_ff;    // Length of the current write strobe.
	logic [CNT_W-1:0] we_gap_cnt_ff;    // Cycles since the last write strobe rose.

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || flash_we_n)
			we_low_cnt_ff <= '0;
		else
			we_low_cnt_ff <= we_low_cnt_ff + CNT_W'(1);
		if (sys_rst || !flash_we_n || sq_ff == SQ_IDLE)
			we_gap_cnt_ff <= '0;
		else
			we_gap_cnt_ff <= we_gap_cnt_ff + CNT_W'(1);
	end

	chk_prot_addr_pattern: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(op_ff == OP_PROT1 && !flash_we_n) |-> (flash_addr[1] && !flash_addr[0] && !flash_addr[6]))
		else $error("protect address pattern wrong during protect pulse");

	chk_prot_pulse_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(op_ff == OP_PROT1 && $rose(flash_we_n)) |-> (we_low_cnt_ff == CNT_W'(PPLH_CYC)))
		else $error("protect pulse length differs from protect pulse time");

	chk_prot_hv_held: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(op_ff == OP_PROT1 && !flash_ce_n) |-> (a9_hv_en && oe_hv_en))
		else $error("protect one cycle without high voltage switches");

	chk_prot2_rst_hv: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(op_ff == OP_PROT2 && sq_ff != SQ_IDLE) |-> reset_hv_en)
		else $error("protect two sequence without high voltage reset");

	chk_prot2_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(op_ff == OP_PROT2 && $fell(flash_we_n) && idx_ff == 3'h2)
		|-> (we_gap_cnt_ff > CNT_W'(PPLH_CYC)))
		else $error("verify issued before protect write time elapsed");

	chk_hold_gap: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(op_ff == OP_SEQ && sq_ff != SQ_IDLE) |-> (we_gap_cnt_ff < CNT_W'(BEH_CYC)))
		else $error("gap between erase cycles exceeds erase hold time");

	chk_done_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(sq_ff == SQ_WAIT && bc_done_w && last_cyc_w) |=> (done_ff && sq_ff == SQ_IDLE))
		else $error("finished operation did not raise done");

endmodule : fep_host

// *** tb/fep_flash_model.sv ***
// Behavioural flash device seen by the host at its pins.
`timescale 1ns/1ns
module fep_flash_model #(
	parameter int         BUSY_NS   = 20000,
	parameter logic [7:0] ERASE_CMD = 8'h30,
	parameter logic [7:0] SUSP_CMD  = 8'hB0
) (
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic        rst_n,
	input  wire logic        hv_a9,
	input  wire logic        hv_oe,
	input  wire logic        hv_rst,
	input  wire logic [20:0] addr,
	input  wire logic [15:0] dq_w,
	output logic [15:0]      dq_r,
	output logic             dq_drv,
	output logic             ready_busy
);
	logic [20:0] cmd_addr = 21'h0; // Address taken on the falling strobe.
	logic [7:0]  cmd_data = 8'h0;  // Command byte taken on the rising strobe.
	logic [31:0] prot = 32'h0;     // One protection flag per 64 Kbyte block.
	logic        busy = 1'b0;      // An automatic erase is running.
	logic        tgl = 1'b0;       // Main toggle bit.
	logic        susp = 1'b0;      // The erase is suspended.
	logic        tgl2 = 1'b0;      // Second toggle bit.
	// A floating ready/busy pin is pulled up, so a suspend reads as ready.
	assign ready_busy = !busy || susp;
	assign dq_drv = !ce_n && !oe_n;
	// Verify reads need the address pin or the reset pin at high voltage.
	assign dq_r = (hv_a9 || hv_rst) ? {15'h0, prot[addr[20:16]]}
		: busy ? {9'h0, tgl, 3'h0, tgl2, 2'h0} : 16'h00FF;
	// The address is latched when the write strobe falls.
	always @(negedge we_n)
		if (!ce_n)
			cmd_addr = addr;
	// Only the low byte matters; a busy erase ignores all commands but suspend, and erase as resume while suspended.
	always @(posedge we_n)
		if (!ce_n)
		begin
			cmd_data = dq_w[7:0];
			if (hv_a9 && hv_oe)
				prot[cmd_addr[20:16]] = 1'b1;
			else if (hv_rst && cmd_addr[1:0] == 2'b10 && !cmd_addr[6])
				prot[cmd_addr[20:16]] = 1'b1;
			else if (cmd_data == SUSP_CMD && busy)
				susp = 1'b1;
			else if (cmd_data == ERASE_CMD && susp)
				susp = 1'b0;
			else if (cmd_data == ERASE_CMD && !busy)
				busy = 1'b1;
		end
	// The erase ends by itself after a fixed time.
	always @(posedge busy)
	begin
		#(BUSY_NS);
		busy = 1'b0;
		susp = 1'b0;
	end
	// A hardware reset abandons the erase at once.
	always @(negedge rst_n)
	begin
		busy = 1'b0;
		susp = 1'b0;
	end
	// Each status read flips the main toggle bit, or the second one while suspended.
	always @(negedge oe_n)
		if (!ce_n && busy && susp)
			tgl2 = !tgl2;
		else if (!ce_n && busy)
			tgl = !tgl;
endmodule : fep_flash_model

// *** tb/tb.sv ***
// Self-checking bench for the flash erase/protect host.
`timescale 1ns/1ns
module tb;
	logic ref_clk = 1'b0, sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, ce_n, we_n, oe_n, rst_n, hvr, hva, hvo, dq_oe, drv, rb;
	logic [20:0] fa;
	logic [15:0] dq_out, dq_in, dq_r, dq_last = 16'h0;
	int err_count = 0, total_checks = 0, we_run = 0, last_we = 0;
	// A released data bus shows the inverse of its last level.
	assign dq_in = dq_oe ? dq_out : drv ? dq_r : ~dq_last;
	fep_host #(.PPLH_CYC(20)) fep_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash_addr(fa), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
		.flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_we_n(we_n),
		.flash_oe_n(oe_n), .flash_reset_n(rst_n), .reset_hv_en(hvr),
		.a9_hv_en(hva), .oe_hv_en(hvo), .ready_busy_in(rb));
	fep_flash_model fep_flash_model_i (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.rst_n(rst_n), .hv_a9(hva), .hv_oe(hvo), .hv_rst(hvr), .addr(fa),
		.dq_w(dq_out),
		.dq_r(dq_r), .dq_drv(drv), .ready_busy(rb));
	initial forever #25 ref_clk = !ref_clk;
	// Length of each write strobe pulse, in clocks.
	always @(posedge ref_clk)
	begin
		dq_last <= dq_in;
		if (we_n === 1'b0)
			we_run = we_run + 1;
		else if (we_run != 0)
		begin
			last_we = we_run;
			we_run = 0;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; waits for pready however long it takes.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Poll status until a masked bit rises, then clear done and refused.
	task automatic wait_st(input logic [31:0] m);
		rd = 32'h0;
		for (int i = 0; i < 3000 && (rd & m) == 32'h0; i++)
			apb(1'b0, 8'h04, 32'h0);
		chk(rd & m, m);
		apb(1'b1, 8'h04, 32'h6);
	endtask : wait_st
	// Load one command byte into entry 0 and send it as a one-cycle sequence.
	task automatic cmd(input logic [7:0] c);
		apb(1'b1, 8'h24, {24'h0, c});
		apb(1'b1, 8'h00, 32'h11);
		wait_st(32'h2);
	endtask : cmd
	// Toggle poll of entry 0, then read back the status that it leaves.
	task automatic tgl_poll();
		apb(1'b1, 8'h00, 32'h5);
		wait_st(32'h2);
		apb(1'b0, 8'h04, 32'h0);
	endtask : tgl_poll
	task automatic t_reset();
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h8);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("test reset done");
	endtask : t_reset
	// Block erase command, then toggle poll and busy while it runs.
	task automatic t_erase();
		apb(1'b1, 8'h20, 32'h0A0000);
		cmd(8'h30);
		chk({11'h0, fep_flash_model_i.cmd_addr}, 32'h0A0000);
		chk({24'h0, fep_flash_model_i.cmd_data}, 32'h30);
		chk(last_we, 1);
		repeat (6) @(posedge ref_clk);
		tgl_poll();
		chk(rd & 32'h38, 32'h10);
		cmd(8'hB0);
		tgl_poll();
		chk(rd & 32'h38, 32'h28);
		cmd(8'h30);
		tgl_poll();
		chk(rd & 32'h38, 32'h10);
		repeat (450) @(posedge ref_clk);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd & 32'h8, 32'h8);
		$display("test erase done");
	endtask : t_erase
	// Protect one refused without high voltage, then done and verified.
	task automatic t_prot();
		apb(1'b1, 8'h20, 32'h050000);
		apb(1'b1, 8'h00, 32'h7);
		wait_st(32'h4);
		apb(1'b1, 8'h08, 32'hC);
		repeat (2) @(posedge ref_clk);
		chk({30'h0, hva, hvo}, 32'h3);
		apb(1'b1, 8'h00, 32'h7);
		wait_st(32'h2);
		chk(last_we, 20);
		chk({11'h0, fep_flash_model_i.cmd_addr} & 32'h43, 32'h2);
		apb(1'b1, 8'h08, 32'h4);
		for (int b = 5; b < 7; b++)
		begin
			apb(1'b1, 8'h20, b << 16);
			apb(1'b1, 8'h00, 32'h3);
			wait_st(32'h2);
			apb(1'b0, 8'h0C, 32'h0);
			chk(rd & 32'hFF, b == 5 ? 32'h1 : 32'h0);
		end
		apb(1'b1, 8'h08, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, rst_n}, 32'h0);
		apb(1'b1, 8'h08, 32'h0);
		// Protect two: refused without the reset switch, then protect and verify block 7.
		apb(1'b1, 8'h00, 32'h9);
		wait_st(32'h4);
		apb(1'b1, 8'h08, 32'h2);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, hvr}, 32'h1);
		for (int e = 0; e < 4; e++)
		begin
			apb(1'b1, 8'h20 + 8'(e * 8), 32'h070000);
			apb(1'b1, 8'h24 + 8'(e * 8), 32'h60);
		end
		apb(1'b1, 8'h00, 32'h9);
		wait_st(32'h2);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd & 32'hFF, 32'h1);
		apb(1'b1, 8'h08, 32'h0);
		$display("test protect done");
	endtask : t_prot
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	initial
	begin
		#(50 * 40000);
		err_count++;
		summarize();
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_erase();
		t_prot();
		summarize();
	end
endmodule : tb
